// >>> design/pmcr_pkg.sv
// shared constants, types and decode helpers for the power management register bank
package pmcr_pkg;

  // ----------------------------------------------------------------
  // configuration offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PM_CAP_ID       = 8'h48;
  localparam logic [7:0] OFF_PM_NEXT_CAPABILITY_POINTER     = 8'h49;
  localparam logic [7:0] OFF_PM_CAPS         = 8'h4a;
  localparam logic [7:0] OFF_POWER_CTRL_STAT = 8'h4c;
  localparam logic [7:0] OFF_BRIDGE_EXT      = 8'h4e;
  localparam logic [7:0] OFF_POWER_DATA      = 8'h4f;
  localparam logic [7:0] OFF_MSI_CAPABILITY_IDENTIFIER      = 8'h50;
  localparam logic [7:0] OFF_NEXT_CAP_PTR    = 8'h51;

  // ----------------------------------------------------------------
  // reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_POWER_CTRL_STAT = 16'h0008;
  localparam logic [7:0]  RST_BRIDGE_EXT      = 8'h40;
  localparam logic [7:0]  VAL_POWER_DATA      = 8'h00;
  localparam logic [7:0]  VAL_MSI_CAPABILITY_IDENTIFIER      = 8'h05;
  localparam logic [7:0]  VAL_NEXT_CAP_PTR    = 8'h70;
  localparam logic [7:0]  VAL_PM_CAP_ID       = 8'h01;
  localparam logic [7:0]  VAL_PM_NEXT_CAPABILITY_POINTER     = 8'h50;
  localparam logic [15:0] VAL_PM_CAPS_BASE    = 16'h0600;
  localparam logic [2:0]  VAL_PM_REV_OLD      = 3'h2;
  localparam logic [2:0]  VAL_PM_REV_NEW      = 3'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_POWER_STATE   = 0;
  localparam int POS_NO_SOFT_RESET = 3;
  localparam int POS_WAKE_SCRATCH  = 8;
  localparam int POS_WAKE_STATUS   = 15;
  localparam int POS_CLOCK_STOP    = 7;
  localparam int POS_BUS_STATE     = 6;
  localparam int POS_PM_REV        = 0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMCR_D0,
    PMCR_D1,
    PMCR_D2,
    PMCR_D3HOT
  } pmcr_power_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  dw;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pmcr_cfg_req_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] pmcr_dw(input logic [7:0] off);
    pmcr_dw = off[7:2];
  endfunction

endpackage

// >>> design/pmcr_state_reg.sv
// writable power state and scratch bits of the control/status register
`timescale 1ns/1ps
`default_nettype none
module pmcr_state_reg (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wrLow,
  input  wire logic        wrHigh,
  input  wire logic [15:0] wdata,
  output pmcr_pkg::pmcr_power_t powerState,
  output logic             wakeEnableScratch,
  output logic             d3hotExit
);

  pmcr_pkg::pmcr_power_t powerState_r;
  pmcr_pkg::pmcr_power_t powerState_nxt;
  logic                  scratch_r;
  logic                  d3hotExit_r;

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  always_comb begin
    powerState_nxt = powerState_r;
    if (wrLow) begin
      powerState_nxt = pmcr_pkg::pmcr_power_t'(wdata[pmcr_pkg::POS_POWER_STATE +: 2]);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      powerState_r <= pmcr_pkg::PMCR_D0;
    end else begin
      powerState_r <= powerState_nxt;
    end
  end

  // ----------------------------------------------------------------
  // scratch bit, no function behind it
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scratch_r <= 1'b0;
    end else if (wrHigh) begin
      scratch_r <= wdata[pmcr_pkg::POS_WAKE_SCRATCH];
    end
  end

  // ----------------------------------------------------------------
  // leaving d3hot: a notice only, context stays untouched
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      d3hotExit_r <= 1'b0;
    end else begin
      d3hotExit_r <= (powerState_r == pmcr_pkg::PMCR_D3HOT) &&
                     (powerState_nxt == pmcr_pkg::PMCR_D0);
    end
  end

  assign powerState        = powerState_r;
  assign wakeEnableScratch = scratch_r;
  assign d3hotExit         = d3hotExit_r;

endmodule
`default_nettype wire

// >>> design/pmcr_read_mux.sv
// read value of each dword that the bank owns
`timescale 1ns/1ps
`default_nettype none
module pmcr_read_mux (
  input  wire logic [5:0]  dw,
  input  wire logic [1:0]  powerState,
  input  wire logic        wakeEnableScratch,
  input  wire logic        revisionSelect,
  input  wire logic        clockStopSelect,
  output logic             hit,
  output logic [31:0]      rdValue
);

  logic [15:0] ctrlStat;
  logic [7:0]  bridgeExt;
  logic [15:0] pmCaps;

  // ----------------------------------------------------------------
  // field assembly; everything not named reads zero
  // ----------------------------------------------------------------
  always_comb begin
    ctrlStat = 16'h0000;
    ctrlStat[pmcr_pkg::POS_POWER_STATE +: 2] = powerState;
    ctrlStat[pmcr_pkg::POS_NO_SOFT_RESET]    = revisionSelect;
    ctrlStat[pmcr_pkg::POS_WAKE_SCRATCH]     = wakeEnableScratch;
    bridgeExt = 8'h00;
    bridgeExt[pmcr_pkg::POS_CLOCK_STOP] = clockStopSelect;
    bridgeExt[pmcr_pkg::POS_BUS_STATE]  = pmcr_pkg::RST_BRIDGE_EXT[pmcr_pkg::POS_BUS_STATE];
    pmCaps = pmcr_pkg::VAL_PM_CAPS_BASE;
    pmCaps[pmcr_pkg::POS_PM_REV +: 3] = revisionSelect ? pmcr_pkg::VAL_PM_REV_NEW
                                                       : pmcr_pkg::VAL_PM_REV_OLD;
  end

  // ----------------------------------------------------------------
  // dword select
  // ----------------------------------------------------------------
  always_comb begin
    hit     = 1'b1;
    rdValue = 32'h0000_0000;
    if (dw == pmcr_pkg::pmcr_dw(pmcr_pkg::OFF_PM_CAP_ID)) begin
      rdValue = {pmCaps, pmcr_pkg::VAL_PM_NEXT_CAPABILITY_POINTER, pmcr_pkg::VAL_PM_CAP_ID};
    end else if (dw == pmcr_pkg::pmcr_dw(pmcr_pkg::OFF_POWER_CTRL_STAT)) begin
      rdValue = {pmcr_pkg::VAL_POWER_DATA, bridgeExt, ctrlStat};
    end else if (dw == pmcr_pkg::pmcr_dw(pmcr_pkg::OFF_MSI_CAPABILITY_IDENTIFIER)) begin
      // upper half is message control, held by another block
      rdValue = {16'h0000, pmcr_pkg::VAL_NEXT_CAP_PTR, pmcr_pkg::VAL_MSI_CAPABILITY_IDENTIFIER};
    end else begin
      hit = 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> design/pmcr_regs.sv
// power management capability register bank, top level
// ----------------------------------------------------------------
// Summary of operation
// - two-bit power state, writable, resets D0
// - no internal reset leaving D3hot for D0
// - bit 3 follows revision select input
// - wake status bit 15 reads zero
// - data scale bits 14:13 read zero
// - data select bits 12:9 read zero
// - bit 8 scratch, read/write, resets zero
// - reserved bits 7:4 and 2 read zero
// - control/status at 4Ch, reset 0008h with revision select set, 0000h with it clear
// - extension bit 7 mirrors clock-stop select
// - extension bit 6 reads one
// - extension bits 5:0 read zero
// - extension register read-only at 4Eh, 40h or C0h by clock-stop select
// - data register at 4Fh reads zero
// - capability id at 50h reads 05h
// - next pointer at 51h reads 70h
// - revision field 010b or 011b by select
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module pmcr_regs (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire pmcr_pkg::pmcr_cfg_req_t cfgReq,
  input  wire logic                   pmRevisionSelect,
  input  wire logic                   secondaryClockStopSelect,
  output logic [31:0]                 cfgRdData,
  output logic                        cfgRdValid,
  output logic [1:0]                  powerState,
  output logic                        wakeEnableScratch,
  output logic                        d3hotExit,
  output logic                        contextRetain
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic                  ctrlDword;
  logic                  wrLow;
  logic                  wrHigh;
  logic                  hit;
  logic [31:0]           rdValue;
  logic [31:0]           cfgRdData_r;
  logic                  cfgRdValid_r;
  pmcr_pkg::pmcr_power_t stateEnum;

  assign ctrlDword = cfgReq.dw == pmcr_pkg::pmcr_dw(pmcr_pkg::OFF_POWER_CTRL_STAT);
  // only byte lanes 0 and 1 of the control dword carry writable bits
  assign wrLow     = cfgReq.wr && ctrlDword && cfgReq.be[0];
  assign wrHigh    = cfgReq.wr && ctrlDword && cfgReq.be[1];

  // ----------------------------------------------------------------
  // writable state
  // ----------------------------------------------------------------
  pmcr_state_reg pmcr_state_reg_inst (
    .clk               (clk),
    .nrst              (nrst),
    .wrLow             (wrLow),
    .wrHigh            (wrHigh),
    .wdata             (cfgReq.wdata[15:0]),
    .powerState        (stateEnum),
    .wakeEnableScratch (wakeEnableScratch),
    .d3hotExit         (d3hotExit)
  );

  assign powerState    = stateEnum;
  // with the newer revision the core keeps context through d3hot
  assign contextRetain = pmRevisionSelect;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  pmcr_read_mux pmcr_read_mux_inst (
    .dw                (cfgReq.dw),
    .powerState        (powerState),
    .wakeEnableScratch (wakeEnableScratch),
    .revisionSelect    (pmRevisionSelect),
    .clockStopSelect   (secondaryClockStopSelect),
    .hit               (hit),
    .rdValue           (rdValue)
  );

  // registered so the answer is a clean flop one cycle after the request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfgRdData_r <= 32'h0000_0000;
    end else if (cfgReq.rd && hit) begin
      cfgRdData_r <= rdValue;
    end else begin
      cfgRdData_r <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfgRdValid_r <= 1'b0;
    end else begin
      cfgRdValid_r <= cfgReq.rd && hit;
    end
  end

  assign cfgRdData  = cfgRdData_r;
  assign cfgRdValid = cfgRdValid_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic rdCtrl;
  logic rdMsi;
  logic rdCaps;
  assign rdCtrl = cfgReq.rd && ctrlDword;
  assign rdMsi  = cfgReq.rd && cfgReq.dw == pmcr_pkg::pmcr_dw(pmcr_pkg::OFF_MSI_CAPABILITY_IDENTIFIER);
  assign rdCaps = cfgReq.rd && cfgReq.dw == pmcr_pkg::pmcr_dw(pmcr_pkg::OFF_PM_CAP_ID);

  property p_state_write;
    wrLow |=> powerState == $past(cfgReq.wdata[1:0]);
  endproperty
  a_state_write: assert property (p_state_write) else $error("power state not written");

  property p_state_hold;
    !wrLow |=> $stable(powerState);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("power state moved without write");

  property p_d3_exit_keeps_scratch;
    (powerState == 2'h3 && wrLow && cfgReq.wdata[1:0] == 2'h0 && !wrHigh)
      |=> d3hotExit && $stable(wakeEnableScratch) ##1 !d3hotExit;
  endproperty
  a_d3_exit_keeps_scratch: assert property (p_d3_exit_keeps_scratch)
    else $error("d3hot exit disturbed context");

  property p_soft_reset_bit;
    rdCtrl |=> cfgRdValid && cfgRdData[3] == $past(pmRevisionSelect);
  endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("bit 3 wrong");

  property p_ctrl_zero_bits;
    rdCtrl |=> cfgRdData[15:9] == 7'h00 && cfgRdData[7:4] == 4'h0 && !cfgRdData[2];
  endproperty
  a_ctrl_zero_bits: assert property (p_ctrl_zero_bits)
    else $error("read-only zero bits nonzero");

  property p_ctrl_live;
    rdCtrl && !cfgReq.wr |=> cfgRdData[1:0] == powerState && cfgRdData[8] == wakeEnableScratch;
  endproperty
  a_ctrl_live: assert property (p_ctrl_live) else $error("writable fields misread");

  property p_bridge_ext;
    rdCtrl |=> cfgRdData[31:16] == {8'h00, $past(secondaryClockStopSelect), 7'h40};
  endproperty
  a_bridge_ext: assert property (p_bridge_ext) else $error("extension or data byte wrong");

  property p_msi_dword;
    rdMsi |=> cfgRdValid && cfgRdData == 32'h0000_7005;
  endproperty
  a_msi_dword: assert property (p_msi_dword) else $error("msi id or pointer wrong");

  property p_revision;
    rdCaps |=> cfgRdData[18:16] == ($past(pmRevisionSelect) ? 3'h3 : 3'h2);
  endproperty
  a_revision: assert property (p_revision) else $error("revision field wrong");

  property p_no_spurious_answer;
    !(cfgReq.rd && hit) |=> !cfgRdValid && cfgRdData == 32'h0000_0000;
  endproperty
  a_no_spurious_answer: assert property (p_no_spurious_answer)
    else $error("answer without a read");

  property p_upper_write_only_scratch;
    wrHigh && !wrLow |=> $stable(powerState) && wakeEnableScratch == $past(cfgReq.wdata[8]);
  endproperty
  a_upper_write_only_scratch: assert property (p_upper_write_only_scratch)
    else $error("upper byte write misbehaved");

  property p_wake_status_zero;
    rdCtrl |=> !cfgRdData[15];
  endproperty
  a_wake_status_zero: assert property (p_wake_status_zero)
    else $error("wake status bit set");

  property p_data_scale_zero;
    rdCtrl |=> cfgRdData[14:13] == 2'h0;
  endproperty
  a_data_scale_zero: assert property (p_data_scale_zero)
    else $error("data scale nonzero");

  property p_data_select_zero;
    rdCtrl |=> cfgRdData[12:9] == 4'h0;
  endproperty
  a_data_select_zero: assert property (p_data_select_zero)
    else $error("data select nonzero");

  property p_reserved_zero;
    rdCtrl |=> cfgRdData[7:4] == 4'h0 && !cfgRdData[2];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits nonzero");

  property p_ctrl_answer;
    rdCtrl |=> cfgRdValid;
  endproperty
  a_ctrl_answer: assert property (p_ctrl_answer)
    else $error("control dword not answered");

  property p_bus_state_one;
    rdCtrl |=> cfgRdData[22];
  endproperty
  a_bus_state_one: assert property (p_bus_state_one)
    else $error("bus state flag clear");

  property p_ext_reserved_zero;
    rdCtrl |=> cfgRdData[21:16] == 6'h00;
  endproperty
  a_ext_reserved_zero: assert property (p_ext_reserved_zero)
    else $error("extension reserved bits nonzero");

  property p_ext_fixed;
    rdCtrl |=> cfgRdData[22:16] == 7'h40;
  endproperty
  a_ext_fixed: assert property (p_ext_fixed)
    else $error("extension fixed bits wrong");

  property p_data_reg_zero;
    rdCtrl |=> cfgRdData[31:24] == 8'h00;
  endproperty
  a_data_reg_zero: assert property (p_data_reg_zero)
    else $error("data register nonzero");

  property p_msi_id;
    rdMsi |=> cfgRdData[7:0] == 8'h05;
  endproperty
  a_msi_id: assert property (p_msi_id)
    else $error("msi id wrong");

  property p_next_capability_pointer;
    rdMsi |=> cfgRdData[15:8] == 8'h70;
  endproperty
  a_next_capability_pointer: assert property (p_next_capability_pointer)
    else $error("next pointer wrong");

  property p_caps_revision_high;
    rdCaps |=> cfgRdValid && cfgRdData[18:17] == 2'h1;
  endproperty
  a_caps_revision_high: assert property (p_caps_revision_high)
    else $error("revision upper bits wrong");

  property p_other_dword_write;
    cfgReq.wr && !ctrlDword |=> $stable(powerState) && $stable(wakeEnableScratch);
  endproperty
  a_other_dword_write: assert property (p_other_dword_write)
    else $error("foreign write changed state");

  property p_scratch_hold;
    !wrHigh |=> $stable(wakeEnableScratch);
  endproperty
  a_scratch_hold: assert property (p_scratch_hold)
    else $error("scratch moved without write");

  property p_scratch_write;
    wrHigh |=> wakeEnableScratch == $past(cfgReq.wdata[8]);
  endproperty
  a_scratch_write: assert property (p_scratch_write)
    else $error("scratch not written");

  property p_exit_pulse;
    powerState == 2'h3 && wrLow && cfgReq.wdata[1:0] == 2'h0 |=> d3hotExit;
  endproperty
  a_exit_pulse: assert property (p_exit_pulse)
    else $error("d3hot exit not flagged");

  property p_exit_source;
    d3hotExit |-> powerState == 2'h0 && $past(powerState) == 2'h3;
  endproperty
  a_exit_source: assert property (p_exit_source)
    else $error("exit flag without d3hot exit");

  property p_exit_single;
    d3hotExit |=> !d3hotExit;
  endproperty
  a_exit_single: assert property (p_exit_single)
    else $error("exit flag longer than one cycle");

  property p_idle_data_zero;
    !cfgRdValid |-> cfgRdData == 32'h0000_0000;
  endproperty
  a_idle_data_zero: assert property (p_idle_data_zero)
    else $error("read data outside answer");

  property p_unowned_silent;
    cfgReq.rd && !hit |=> !cfgRdValid;
  endproperty
  a_unowned_silent: assert property (p_unowned_silent)
    else $error("foreign dword answered");

  c_enter_d3: cover property (wrLow && cfgReq.wdata[1:0] == 2'h3);
  c_d3_exit: cover property (d3hotExit);
  c_read_ctrl: cover property (rdCtrl ##1 cfgRdValid);
  c_read_msi: cover property (rdMsi ##1 cfgRdValid);
  c_upper_only_write: cover property (wrHigh && !wrLow);

endmodule
`default_nettype wire

// >>> verification/pmcr_regs_tb.sv
// self-checking bench for the power management register bank
`timescale 1ns/1ps
`default_nettype none
module pmcr_regs_tb;
  logic                    clk;
  logic                    nrst;
  pmcr_pkg::pmcr_cfg_req_t cfgReq;
  logic                    revSel;
  logic                    clkStopSel;
  logic [31:0]             cfgRdData;
  logic                    cfgRdValid;
  logic [1:0]              powerState;
  logic                    wakeEnableScratch;
  logic                    d3hotExit;
  logic                    contextRetain;
  int                      n_fail;
  int                      compares;

  pmcr_regs pmcr_regs_inst (
    .clk                      (clk),
    .nrst                     (nrst),
    .cfgReq                   (cfgReq),
    .pmRevisionSelect         (revSel),
    .secondaryClockStopSelect (clkStopSel),
    .cfgRdData                (cfgRdData),
    .cfgRdValid               (cfgRdValid),
    .powerState               (powerState),
    .wakeEnableScratch        (wakeEnableScratch),
    .d3hotExit                (d3hotExit),
    .contextRetain            (contextRetain)
  );

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk32(what, {31'h0, exp}, {31'h0, got});
  endtask

  // one access; returns 1 ns after the edge that took it
  task automatic cfgAccess(input logic w, input logic [5:0] dw, input logic [3:0] be,
                           input logic [31:0] wd);
    @(posedge clk);
    cfgReq <= '{wr: w, rd: !w, dw: dw, be: be, wdata: wd};
    @(posedge clk);
    cfgReq <= '0;
    #1;
  endtask

  task automatic readChk(input string what, input logic [5:0] dw, input logic [31:0] exp);
    cfgAccess(1'b0, dw, 4'h0, 32'h0);
    chk1({what, " valid"}, 1'b1, cfgRdValid);
    chk32(what, exp, cfgRdData);
  endtask

  // expected dword at 4Ch from the current select inputs
  function automatic logic [31:0] pmDw(input logic [1:0] st, input logic scr);
    pmDw = {8'h00, clkStopSel, 1'b1, 6'h0, 7'h0, scr, 4'h0, revSel, 1'b0, st};
  endfunction

  function automatic logic [31:0] capDw();
    capDw = {13'h00c0, 2'b01, revSel, 8'h50, 8'h01};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic tResetValues();
    #1;
    chk32("state0", 32'h0, {30'h0, powerState});
    chk1("scratch", 1'b0, wakeEnableScratch);
    chk1("exit rst", 1'b0, d3hotExit);
    readChk("ctrlstat reset", 6'h13, 32'h0040_0008);
    @(posedge clk);
    #1;
    chk1("valid drop", 1'b0, cfgRdValid);
    chk32("data drop", 32'h0, cfgRdData);
  endtask

  task automatic tSelects();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      revSel     <= i[1];
      clkStopSel <= i[0];
      @(posedge clk);
      #1;
      chk1("retain", revSel, contextRetain);
      readChk("ctrlstat sel", 6'h13, pmDw(2'h0, 1'b0));
      readChk("caps sel", 6'h12, capDw());
    end
  endtask

  task automatic tAllStates();
    for (int s = 0; s < 4; s++) begin
      cfgAccess(1'b1, 6'h13, 4'h1, {30'h0, s[1:0]});
      chk32("state", {30'h0, s[1:0]}, {30'h0, powerState});
      readChk("ctrlstat state", 6'h13, pmDw(s[1:0], 1'b0));
    end
  endtask

  task automatic tD3Exit();
    cfgAccess(1'b1, 6'h13, 4'h3, 32'h0000_0103);
    chk1("no exit yet", 1'b0, d3hotExit);
    cfgAccess(1'b1, 6'h13, 4'h1, 32'h0000_0000);
    chk1("exit pulse", 1'b1, d3hotExit);
    chk32("state d0", 32'h0, {30'h0, powerState});
    @(posedge clk);
    #1;
    chk1("exit drop", 1'b0, d3hotExit);
    chk1("scratch kept", 1'b1, wakeEnableScratch);
    readChk("ctrlstat exit", 6'h13, pmDw(2'h0, 1'b1));
  endtask

  task automatic tReadOnly();
    cfgAccess(1'b1, 6'h13, 4'hf, 32'hffff_ffff);
    readChk("ctrlstat ones", 6'h13, pmDw(2'h3, 1'b1));
    cfgAccess(1'b1, 6'h13, 4'he, 32'h0000_0000);
    readChk("lane0 off", 6'h13, pmDw(2'h3, 1'b0));
    cfgAccess(1'b1, 6'h12, 4'hf, 32'hffff_ffff);
    cfgAccess(1'b1, 6'h14, 4'hf, 32'h0000_0000);
    readChk("caps ro", 6'h12, capDw());
    readChk("msi ro", 6'h14, 32'h0000_7005);
  endtask

  task automatic tUnmapped();
    cfgAccess(1'b0, 6'h15, 4'h0, 32'h0);
    chk1("unmapped", 1'b0, cfgRdValid);
    chk32("unmapped data", 32'h0, cfgRdData);
  endtask

  task automatic tMidReset();
    cfgAccess(1'b1, 6'h13, 4'h3, 32'h0000_0102);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    #1;
    chk32("rst state", 32'h0, {30'h0, powerState});
    chk1("rst scratch", 1'b0, wakeEnableScratch);
    chk1("rst valid", 1'b0, cfgRdValid);
    @(posedge clk);
    nrst <= 1'b1;
    readChk("after rst", 6'h13, pmDw(2'h0, 1'b0));
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // generous: the whole sequence needs well under 200 cycles
  initial begin
    #20000;
    n_fail++;
    conclude();
  end

  initial begin
    clk        = 1'b0;
    nrst       = 1'b0;
    cfgReq     = '0;
    revSel     = 1'b1;
    clkStopSel = 1'b0;
    n_fail     = 0;
    compares   = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    tResetValues();
    tSelects();
    tAllStates();
    tD3Exit();
    tReadOnly();
    tUnmapped();
    tMidReset();
    conclude();
  end
endmodule
`default_nettype wire
